// >>> src/onllb_top.sv
// Summary of operation
// R1: Or mode outputs true if any connected input true, false if all false.
// R2: Nor mode outputs false if any connected input true, true if all false.
// R3: Only connected inputs take part; unconnected inputs are ignored. The latch reads inputs 0 and 1 without their connection flag.
// R4: Function setting selects Off, Or, Nor or Latch operation.
// R5: Undeterminable result takes value and error from the error-handling setting.
// R6: Error handling offers true good, true bad, false good, false bad.
// R7: Latch mode output follows the data input while freeze is false.
// R8: Freeze rising captures data input; output stays fixed while freeze holds.
// R9: Data rising after freeze went true leaves output false until release.
// R10: Freeze rising while data true keeps output true until release.
// R11: Eight digital inputs and one digital output in Or and Nor modes.
// R12: Freeze false or errored: output value and error follow data input.
// R13: Data error during valid freeze keeps the value captured at freeze.
// R14: Or/Nor ignore input errors when good inputs decide; else error handling.
// R15: Output carries the error status of the input it is sourced from.
//
// The address map and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

module onllb_top
  import onllb_pkg::*;
#(
  parameter int NUM_IN = ONLLB_NUM_IN,
  parameter int ADDR_W = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire onllb_in_t [NUM_IN-1:0] in_sig,
  output logic out_val,
  output logic out_err,
  output logic irq
);

  // ----------------------------------------------------------------
  // Input synchroniser
  // ----------------------------------------------------------------
  onllb_in_t [NUM_IN-1:0] sync1_reg;
  onllb_in_t [NUM_IN-1:0] sync2_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else if (ce) begin
      sync1_reg <= in_sig;
      sync2_reg <= sync1_reg;
    end
  end

  // ----------------------------------------------------------------
  // Per-input decode
  // ----------------------------------------------------------------
  logic [NUM_IN-1:0] good_true;
  logic [NUM_IN-1:0] conn_err;
  logic [NUM_IN-1:0] conn_vec;
  logic [NUM_IN-1:0] val_vec;
  logic [NUM_IN-1:0] err_vec;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_IN; gi = gi + 1) begin : g_in
      assign conn_vec[gi] = sync2_reg[gi].conn;
      assign val_vec[gi] = sync2_reg[gi].val;
      assign err_vec[gi] = sync2_reg[gi].err;
      assign good_true[gi] = sync2_reg[gi].conn && !sync2_reg[gi].err
                             && sync2_reg[gi].val; // R3
      assign conn_err[gi] = sync2_reg[gi].conn && sync2_reg[gi].err; // R3
    end
  endgenerate

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  logic [31:0] ctrl_reg;
  logic [ONLLB_EV_W-1:0] stat_reg;
  logic [ONLLB_EV_W-1:0] mask_reg;
  wire onllb_mode_t mode;
  wire onllb_eh_t eh_sel;
  wire onllb_dsig_t eh_res;

  assign mode = onllb_mode_t'(ctrl_reg[ONLLB_CTRL_MODE_LSB +: 2]); // R4
  assign eh_sel = onllb_eh_t'(ctrl_reg[ONLLB_CTRL_EH_LSB +: 2]); // R6
  assign eh_res = onllb_eh_result(eh_sel); // R6

  // ----------------------------------------------------------------
  // Or / Nor evaluation
  // ----------------------------------------------------------------
  wire logic any_true;
  wire logic indet;
  wire onllb_dsig_t or_res;

  assign any_true = |good_true;
  // Undecided when no good input is true and some connected input is errored or none connected
  assign indet = !any_true && ((|conn_err) || !(|conn_vec)); // R14
  assign or_res.val = indet ? eh_res.val : (any_true ^ (mode == ONLLB_MODE_NOR)); // R1 R2 R5
  assign or_res.err = indet ? eh_res.err : 1'b0; // R5 R14

  // ----------------------------------------------------------------
  // Latch (input 0 is data, input 1 is freeze)
  // ----------------------------------------------------------------
  wire onllb_dsig_t lat_data;
  wire onllb_dsig_t lat_freeze;
  wire onllb_dsig_t lat_res;
  wire logic lat_hold;
  wire logic lat_en;

  assign lat_data.val = sync2_reg[0].val;
  assign lat_data.err = sync2_reg[0].err;
  assign lat_freeze.val = sync2_reg[1].val;
  assign lat_freeze.err = sync2_reg[1].err;
  assign lat_en = (mode == ONLLB_MODE_LATCH);

  onllb_latch u_latch (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .enable(lat_en),
    .data_in(lat_data),
    .freeze_in(lat_freeze),
    .holding(lat_hold),
    .result(lat_res)
  );

  // ----------------------------------------------------------------
  // Output selection
  // ----------------------------------------------------------------
  onllb_dsig_t out_reg;
  onllb_dsig_t out_next;
  wire logic use_logic;

  assign use_logic = (mode == ONLLB_MODE_OR) || (mode == ONLLB_MODE_NOR); // R11
  assign out_next = use_logic ? or_res :
                    lat_en ? lat_res : '0; // R4 R15

  // ----------------------------------------------------------------
  // Interrupt events
  // ----------------------------------------------------------------
  logic indet_reg;
  logic [ONLLB_EV_W-1:0] events;
  logic [ONLLB_EV_W-1:0] stat_clr;
  logic [ONLLB_EV_W-1:0] stat_next;
  wire logic irq_next;

  assign events[ONLLB_EV_RISE] = out_next.val && !out_reg.val;
  assign events[ONLLB_EV_FALL] = !out_next.val && out_reg.val;
  assign events[ONLLB_EV_ERR] = out_next.err && !out_reg.err;
  assign events[ONLLB_EV_INDET] = use_logic && indet && !indet_reg;
  // A new event wins over a clear in the same cycle
  assign stat_next = (stat_reg & ~stat_clr) | events;
  assign irq_next = |(stat_reg & mask_reg);

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  logic aw_got_reg;
  logic w_got_reg;
  logic [ADDR_W-1:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic wstrb0_reg;
  wire logic aw_hs, w_hs, ar_hs, do_write;
  wire logic aw_got_next, w_got_next, bvalid_next, rvalid_next;
  wire logic wr_ctrl, wr_stat, wr_mask, wr_hit, rd_hit;
  logic [31:0] rd_word;
  logic [31:0] status_word;

  function automatic logic reg_hit(input logic [ADDR_W-1:0] a);
    return (a == ONLLB_OFF_CTRL) || (a == ONLLB_OFF_STATUS)
           || (a == ONLLB_OFF_INT_STAT) || (a == ONLLB_OFF_INT_MASK);
  endfunction

  assign aw_hs = s_axi_awvalid && s_axi_awready;
  assign w_hs = s_axi_wvalid && s_axi_wready;
  assign ar_hs = s_axi_arvalid && s_axi_arready;
  assign do_write = aw_got_reg && w_got_reg && !s_axi_bvalid;
  assign aw_got_next = do_write ? 1'b0 : (aw_got_reg || aw_hs);
  assign w_got_next = do_write ? 1'b0 : (w_got_reg || w_hs);
  assign bvalid_next = do_write || (s_axi_bvalid && !s_axi_bready);
  assign rvalid_next = ar_hs || (s_axi_rvalid && !s_axi_rready);

  assign wr_hit = reg_hit(awaddr_reg);
  assign wr_ctrl = do_write && wstrb0_reg && (awaddr_reg == ONLLB_OFF_CTRL);
  assign wr_stat = do_write && wstrb0_reg && (awaddr_reg == ONLLB_OFF_INT_STAT);
  assign wr_mask = do_write && wstrb0_reg && (awaddr_reg == ONLLB_OFF_INT_MASK);
  assign stat_clr = wr_stat ? wdata_reg[ONLLB_EV_W-1:0] : '0;
  assign rd_hit = reg_hit(s_axi_araddr);

  always_comb begin
    status_word = '0;
    status_word[ONLLB_ST_VAL] = out_reg.val;
    status_word[ONLLB_ST_ERR] = out_reg.err;
    status_word[ONLLB_ST_INDET] = indet_reg;
    status_word[ONLLB_ST_HOLD] = lat_hold;
    status_word[ONLLB_ST_INVAL_LSB +: NUM_IN] = val_vec;
    status_word[ONLLB_ST_INERR_LSB +: NUM_IN] = err_vec;
    status_word[ONLLB_ST_INCONN_LSB +: NUM_IN] = conn_vec;
    case (s_axi_araddr)
      ONLLB_OFF_CTRL: rd_word = ctrl_reg;
      ONLLB_OFF_STATUS: rd_word = status_word;
      ONLLB_OFF_INT_STAT: rd_word = {{(32-ONLLB_EV_W){1'b0}}, stat_reg};
      ONLLB_OFF_INT_MASK: rd_word = {{(32-ONLLB_EV_W){1'b0}}, mask_reg};
      default: rd_word = '0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= '0;
      wstrb0_reg <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= ONLLB_RESP_OKAY;
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= ONLLB_RESP_OKAY;
    end else if (ce) begin
      aw_got_reg <= aw_got_next;
      w_got_reg <= w_got_next;
      if (aw_hs) begin
        awaddr_reg <= s_axi_awaddr;
      end
      if (w_hs) begin
        wdata_reg <= s_axi_wdata;
        wstrb0_reg <= s_axi_wstrb[0];
      end
      s_axi_awready <= !aw_got_next && !bvalid_next;
      s_axi_wready <= !w_got_next && !bvalid_next;
      s_axi_bvalid <= bvalid_next;
      if (do_write) begin
        s_axi_bresp <= wr_hit ? ONLLB_RESP_OKAY : ONLLB_RESP_SLVERR;
      end
      s_axi_arready <= !rvalid_next;
      s_axi_rvalid <= rvalid_next;
      if (ar_hs) begin
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_hit ? ONLLB_RESP_OKAY : ONLLB_RESP_SLVERR;
      end
    end
  end

  // ----------------------------------------------------------------
  // Block state
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= ONLLB_CTRL_RST;
      mask_reg <= ONLLB_MASK_RST;
      stat_reg <= '0;
      out_reg <= '0;
      indet_reg <= 1'b0;
      irq <= 1'b0;
    end else if (ce) begin
      if (wr_ctrl) begin
        ctrl_reg <= {24'h000000, 2'b00, wdata_reg[ONLLB_CTRL_EH_LSB +: 2],
                     2'b00, wdata_reg[ONLLB_CTRL_MODE_LSB +: 2]};
      end
      if (wr_mask) begin
        mask_reg <= wdata_reg[ONLLB_EV_W-1:0];
      end
      stat_reg <= stat_next;
      out_reg <= out_next;
      indet_reg <= use_logic && indet;
      irq <= irq_next;
    end
  end

  assign out_val = out_reg.val;
  assign out_err = out_reg.err;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_or_any_true: assert property ( // R1
    ce && mode == ONLLB_MODE_OR && any_true |=> out_val && !out_err)
    else $error("Or output not true with a good true input");
  chk_or_all_false: assert property ( // R1
    ce && mode == ONLLB_MODE_OR && (|conn_vec) && !(|conn_err) && !any_true
    |=> !out_val && !out_err)
    else $error("Or output not false with all inputs false");
  chk_nor_any_true: assert property ( // R2
    ce && mode == ONLLB_MODE_NOR && any_true |=> !out_val && !out_err)
    else $error("Nor output not false with a good true input");
  chk_nor_all_false: assert property ( // R2
    ce && mode == ONLLB_MODE_NOR && (|conn_vec) && !(|conn_err) && !any_true
    |=> out_val && !out_err)
    else $error("Nor output not true with all inputs false");
  chk_eh_result: assert property ( // R5
    ce && use_logic && indet |=> out_val == $past(eh_res.val) && out_err == $past(eh_res.err))
    else $error("Undecided result does not follow error handling");
  chk_latch_follow: assert property ( // R7
    ce && lat_en && !lat_hold |=> out_val == $past(lat_data.val)
    && out_err == $past(lat_data.err))
    else $error("Latch output does not follow data while free");
  chk_latch_hold: assert property ( // R8
    ce && lat_en && lat_hold ##1 ce && lat_en && lat_hold |=> $stable(out_reg))
    else $error("Latch output changed while frozen");
  chk_off_false: assert property ( // R4
    ce && mode == ONLLB_MODE_OFF |=> !out_val && !out_err)
    else $error("Off mode output not false without error");
  chk_irq_gate: assert property (
    ce |=> irq == |($past(stat_reg) & $past(mask_reg)))
    else $error("Interrupt output does not match masked status");

  cov_or_true: cover property (ce && mode == ONLLB_MODE_OR && any_true);
  cov_indet: cover property (ce && use_logic && indet && (|conn_err));
  cov_latch_hold: cover property (ce && lat_en && lat_hold ##1 ce && lat_en && lat_hold);
  cov_irq: cover property (irq);

endmodule

`default_nettype wire

// >>> src/onllb_pkg.sv
package onllb_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [3:0] ONLLB_OFF_CTRL = 4'h0;
  localparam logic [3:0] ONLLB_OFF_STATUS = 4'h4;
  localparam logic [3:0] ONLLB_OFF_INT_STAT = 4'h8;
  localparam logic [3:0] ONLLB_OFF_INT_MASK = 4'hc;

  localparam int ONLLB_CTRL_MODE_LSB = 0;
  localparam int ONLLB_CTRL_EH_LSB = 4;
  localparam logic [31:0] ONLLB_CTRL_RST = 32'h0000_0000;
  localparam logic [3:0] ONLLB_MASK_RST = 4'h0;

  localparam int ONLLB_ST_VAL = 0;
  localparam int ONLLB_ST_ERR = 1;
  localparam int ONLLB_ST_INDET = 2;
  localparam int ONLLB_ST_HOLD = 3;
  localparam int ONLLB_ST_INVAL_LSB = 8;
  localparam int ONLLB_ST_INERR_LSB = 16;
  localparam int ONLLB_ST_INCONN_LSB = 24;

  // Interrupt event bits
  localparam int ONLLB_EV_RISE = 0;
  localparam int ONLLB_EV_FALL = 1;
  localparam int ONLLB_EV_ERR = 2;
  localparam int ONLLB_EV_INDET = 3;
  localparam int ONLLB_EV_W = 4;

  localparam logic [1:0] ONLLB_RESP_OKAY = 2'h0;
  localparam logic [1:0] ONLLB_RESP_SLVERR = 2'h2;

  localparam int ONLLB_NUM_IN = 8;
  localparam int ONLLB_SYNC_STAGES = 2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ONLLB_MODE_OFF = 2'b00,
    ONLLB_MODE_OR = 2'b01,
    ONLLB_MODE_NOR = 2'b10,
    ONLLB_MODE_LATCH = 2'b11
  } onllb_mode_t;

  typedef enum logic [1:0] {
    ONLLB_EH_TRUE_GOOD = 2'b00,
    ONLLB_EH_TRUE_BAD = 2'b01,
    ONLLB_EH_FALSE_GOOD = 2'b10,
    ONLLB_EH_FALSE_BAD = 2'b11
  } onllb_eh_t;

  // Digital signal between function blocks
  typedef struct packed {
    logic val;
    logic err;
  } onllb_dsig_t;

  // Receiver port: connection flag plus signal
  typedef struct packed {
    logic conn;
    logic err;
    logic val;
  } onllb_in_t;

  // Result chosen by the error-handling setting
  function automatic onllb_dsig_t onllb_eh_result(input onllb_eh_t eh);
    onllb_dsig_t r;
    r.val = (eh == ONLLB_EH_TRUE_GOOD) || (eh == ONLLB_EH_TRUE_BAD);
    r.err = (eh == ONLLB_EH_TRUE_BAD) || (eh == ONLLB_EH_FALSE_BAD);
    return r;
  endfunction

endpackage

// >>> src/onllb_latch.sv
`timescale 1ns/100ps
`default_nettype none

module onllb_latch
  import onllb_pkg::*;
(
  aclk,
  aresetn,
  ce,
  enable,
  data_in,
  freeze_in,
  holding,
  result
);
  input wire logic aclk;
  input wire logic aresetn;
  input wire logic ce;
  input wire logic enable;
  input wire onllb_dsig_t data_in;
  input wire onllb_dsig_t freeze_in;
  output logic holding;
  output onllb_dsig_t result;

  logic was_holding_reg;
  logic was_holding_next;
  onllb_dsig_t cap_reg;
  onllb_dsig_t cap_next;
  wire logic hold_rise;

  // An errored freeze input never holds
  assign holding = freeze_in.val && !freeze_in.err; // R12
  assign hold_rise = holding && !was_holding_reg;
  assign was_holding_next = enable && holding;
  assign cap_next = hold_rise ? data_in : cap_reg; // R8 R13
  // Follow while free; on the rising edge pass the present input, then keep it
  assign result = (holding && was_holding_reg) ? cap_reg : data_in; // R7 R9 R10

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      was_holding_reg <= 1'b0;
      cap_reg <= '0;
    end else if (ce) begin
      was_holding_reg <= was_holding_next;
      cap_reg <= cap_next;
    end
  end

endmodule

`default_nettype wire

// >>> verif/onllb_src_model.sv
`timescale 1ns/100ps
`default_nettype none

module onllb_src_model
  import onllb_pkg::*;
(
  input wire logic aclk,
  input wire logic [7:0] conn,
  input wire logic [7:0] err,
  input wire logic [7:0] val,
  output var onllb_in_t [7:0] in_sig
);
  // Upstream blocks update once per clock; an unlinked source is not
  // driven, so its value and error wander from cycle to cycle
  logic tgl_reg = 1'b0;

  always_ff @(posedge aclk) begin
    tgl_reg <= ~tgl_reg;
    for (int i = 0; i < 8; i++) begin
      in_sig[i].conn <= conn[i];
      in_sig[i].err <= conn[i] ? err[i] : tgl_reg;
      in_sig[i].val <= conn[i] ? val[i] : ~tgl_reg;
    end
  end
endmodule

`default_nettype wire

// >>> verif/onllb_top_bench.sv
`timescale 1ns/100ps
`default_nettype none

module onllb_top_bench;
  import onllb_pkg::*;

  localparam logic [4:0] A_CTRL = {1'b0, ONLLB_OFF_CTRL};
  localparam logic [4:0] A_ST = {1'b0, ONLLB_OFF_STATUS};
  localparam logic [4:0] A_STAT = {1'b0, ONLLB_OFF_INT_STAT};
  localparam logic [4:0] A_MASK = {1'b0, ONLLB_OFF_INT_MASK};
  localparam logic [1:0] OK = ONLLB_RESP_OKAY;

  logic aclk, aresetn, ce;
  logic [4:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, out_val, out_err, irq;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [7:0] s_conn, s_err, s_val;
  onllb_in_t [7:0] in_sig;
  int miscompares = 0;
  int total_checks = 0;
  int cycles = 0;

  onllb_src_model u_onllb_src_model (
    .aclk(aclk), .conn(s_conn), .err(s_err), .val(s_val), .in_sig(in_sig)
  );

  onllb_top #(.NUM_IN(8), .ADDR_W(5)) u_onllb_top (
    .aclk(aclk), .aresetn(aresetn), .ce(ce),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .in_sig(in_sig),
    .out_val(out_val), .out_err(out_err), .irq(irq)
  );

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      summarize();
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("checks=%0d miscompares=%0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (!aw_done && awready) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_done && wready) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!bvalid);
    bready <= 1'b0;
    check(bresp, er);
    @(posedge aclk);
  endtask

  task automatic rd(input logic [4:0] a, input logic [31:0] exp, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    rready <= 1'b0;
    check(rdata, exp);
    check(rresp, er);
    @(posedge aclk);
  endtask

  // Upstream blocks change, then wait out model, sync and output stages
  task automatic step(input logic [7:0] c, input logic [7:0] e, input logic [7:0] v,
                      input logic [1:0] exp);
    s_conn <= c;
    s_err <= e;
    s_val <= v;
    repeat (5) @(posedge aclk);
    check({out_err, out_val}, exp);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    check({out_err, out_val, irq}, 3'b000);
    rd(A_CTRL, ONLLB_CTRL_RST, OK);
    rd(A_MASK, {28'h0, ONLLB_MASK_RST}, OK);
    rd(5'h10, 32'h0, ONLLB_RESP_SLVERR);
    wr(5'h10, 32'h3, ONLLB_RESP_SLVERR);
    // A write without its low byte lane must leave the register alone
    wstrb <= 4'h0;
    wr(A_CTRL, 32'h3, OK);
    wstrb <= 4'hf;
    rd(A_CTRL, 32'h0, OK);
    $display("test reset done");
  endtask

  task automatic t_logic();
    logic [7:0] cn [5] = '{8'hff, 8'hff, 8'h0f, 8'h01, 8'hff};
    logic [7:0] vl [5] = '{8'h00, 8'h80, 8'hf0, 8'h01, 8'hff};
    logic ex [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
    wr(A_CTRL, 32'h11, OK);
    for (int i = 0; i < 5; i++) begin
      step(cn[i], 8'h00, vl[i], {1'b0, ex[i]});
    end
    wr(A_CTRL, 32'h12, OK);
    rd(A_CTRL, 32'h12, OK);
    for (int i = 0; i < 5; i++) begin
      step(cn[i], 8'h00, vl[i], {1'b0, ~ex[i]});
    end
    $display("test or_nor done");
  endtask

  task automatic t_err();
    wr(A_CTRL, 32'h31, OK);
    step(8'h03, 8'h01, 8'h03, 2'b01);
    for (int e = 0; e < 4; e++) begin
      wr(A_CTRL, 32'h01 | (e << 4), OK);
      step(8'hff, 8'h01, 8'h01, {e[0], e < 2});
    end
    rd(A_ST, 32'hff01_0106, OK);
    wr(A_CTRL, 32'h30, OK);
    step(8'hff, 8'h00, 8'hff, 2'b00);
    $display("test error_handling done");
  endtask

  // Bit 0 carries the data input, bit 1 the freeze input
  task automatic t_latch();
    wr(A_CTRL, 32'h13, OK);
    step(8'h03, 8'h00, 8'h01, 2'b01);
    step(8'h03, 8'h00, 8'h00, 2'b00);
    step(8'h03, 8'h00, 8'h02, 2'b00);
    step(8'h03, 8'h00, 8'h03, 2'b00);
    step(8'h03, 8'h00, 8'h01, 2'b01);
    step(8'h03, 8'h00, 8'h03, 2'b01);
    step(8'h03, 8'h00, 8'h02, 2'b01);
    step(8'hff, 8'h00, 8'h02, 2'b01);
    rd(A_ST, 32'hff00_0209, OK);
    step(8'h03, 8'h01, 8'h02, 2'b01);
    step(8'h03, 8'h01, 8'h00, 2'b10);
    step(8'h03, 8'h02, 8'h03, 2'b01);
    step(8'h03, 8'h02, 8'h02, 2'b00);
    $display("test latch done");
  endtask

  task automatic t_irq();
    wr(A_CTRL, 32'h21, OK);
    step(8'hff, 8'h00, 8'h00, 2'b00);
    wr(A_STAT, 32'hf, OK);
    wr(A_MASK, 32'h1, OK);
    rd(A_MASK, 32'h1, OK);
    check(irq, 1'b0);
    step(8'hff, 8'h00, 8'h04, 2'b01);
    repeat (2) @(posedge aclk);
    check(irq, 1'b1);
    rd(A_STAT, 32'h1, OK);
    wr(A_STAT, 32'h1, OK);
    repeat (2) @(posedge aclk);
    check(irq, 1'b0);
    step(8'hff, 8'h00, 8'h00, 2'b00);
    repeat (2) @(posedge aclk);
    check(irq, 1'b0);
    rd(A_STAT, 32'h2, OK);
    $display("test interrupt done");
  endtask

  // Clock enable low freezes sync and output stages
  task automatic t_ce();
    ce <= 1'b0;
    step(8'hff, 8'h00, 8'h01, 2'b00);
    ce <= 1'b1;
    step(8'hff, 8'h00, 8'h01, 2'b01);
    $display("test clock_enable done");
  endtask

  initial begin
    aresetn = 1'b0;
    ce = 1'b1;
    awaddr = 5'h0;
    araddr = 5'h0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    wdata = 32'h0;
    wstrb = 4'hf;
    s_conn = 8'h00;
    s_err = 8'h00;
    s_val = 8'h00;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_logic();
    t_err();
    t_latch();
    t_irq();
    t_ce();
    summarize();
  end
endmodule

`default_nettype wire
